/* File: rtl/foc_pkg.sv */
package foc_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 12;
  localparam int TMR_W = 12;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_STAT = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_CHK = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PFC = 12'h00C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [5:0] PFC_RST = 6'h13;

  // Clock rate and the printed times, in nanoseconds.
  localparam int CLK_MHZ = 250;
  localparam int NS_PER_US = 1000;
  localparam int PSUS_TYP_NS = 9400;
  localparam int PSUS_MAX_NS = 11500;
  localparam int ESUS_TYP_NS = 16000;
  localparam int ESUS_MAX_NS = 20800;
  localparam int SUS_EXTRA_CYC = 4;
  localparam int RES_MAX_NS = 100;
  localparam int START_MAX_NS = 5;
  localparam int RCV_MIN_NS = 16000;
  localparam int RCV_MAX_NS = 45000;
  localparam int RCV_EXTRA_CYC = 7;
  localparam int AI_STOP_MAX_NS = 80;
  localparam int AI_EXTRA_CYC = 15;
  localparam int MR_STOP_MIN_NS = 10360;
  localparam int MR_STOP_MAX_NS = 20420;

  // Cycle counts: least times round up, longest times round down.
  localparam int PSUS_CYC = PSUS_TYP_NS * CLK_MHZ / NS_PER_US + SUS_EXTRA_CYC;
  localparam int PSUS_MAX_CYC = PSUS_MAX_NS * CLK_MHZ / NS_PER_US + SUS_EXTRA_CYC;
  localparam int ESUS_CYC = ESUS_TYP_NS * CLK_MHZ / NS_PER_US + SUS_EXTRA_CYC;
  localparam int ESUS_MAX_CYC = ESUS_MAX_NS * CLK_MHZ / NS_PER_US + SUS_EXTRA_CYC;
  localparam int RES_MAX_CYC = RES_MAX_NS * CLK_MHZ / NS_PER_US;
  localparam int START_MAX_CYC = (START_MAX_NS * CLK_MHZ / NS_PER_US < 1) ? 1 : START_MAX_NS * CLK_MHZ / NS_PER_US;
  localparam int RCV_CYC = (RCV_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US + RCV_EXTRA_CYC;
  localparam int RCV_MAX_CYC = RCV_MAX_NS * CLK_MHZ / NS_PER_US + RCV_EXTRA_CYC;
  localparam int AI_STOP_CYC = AI_STOP_MAX_NS * CLK_MHZ / NS_PER_US + AI_EXTRA_CYC;
  localparam int MR_STOP_CYC = (MR_STOP_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US + SUS_EXTRA_CYC;
  localparam int MR_STOP_MAX_CYC = MR_STOP_MAX_NS * CLK_MHZ / NS_PER_US + SUS_EXTRA_CYC;

  // Modelled array operation lengths in cycles.
  localparam logic [TMR_W-1:0] PGM_RUN_CYC = 12'hBB8;
  localparam logic [TMR_W-1:0] ERS_RUN_CYC = 12'hFA0;
  localparam logic [TMR_W-1:0] AI_RUN_CYC = 12'h800;
  localparam logic [TMR_W-1:0] MR_RUN_CYC = 12'hBB8;
  localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;

  // Control word of module_config_reg, bit 0 is high_voltage_enable.
  typedef struct packed {
    logic low_power;
    logic erase_sel;
    logic erase_suspend;
    logic program_suspend;
    logic high_voltage_enable;
  } foc_ctrl_t;

  // Control word of user_test_reg0, bit 0 is integrity_check_enable.
  typedef struct packed {
    logic margin_sel;
    logic integrity_breakpoint_ctrl;
    logic integrity_check_suspend;
    logic integrity_check_enable;
  } foc_chk_t;

  typedef enum logic [2:0] {SEL_CTRL, SEL_STAT, SEL_CHK, SEL_PFC, SEL_NONE} foc_sel_t;
  typedef enum {F_IDLE, F_RUN, F_SUSP_WAIT, F_SUSP, F_ABORT, F_END} foc_fst_t;
  typedef enum {C_IDLE, C_RUN, C_STOP, C_SUSP, C_BRK, C_END} foc_cst_t;

  // Word address decode shared by the read and write paths.
  function automatic foc_sel_t foc_decode(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_CTRL: foc_decode = SEL_CTRL;
      OFF_STAT: foc_decode = SEL_STAT;
      OFF_CHK: foc_decode = SEL_CHK;
      OFF_PFC: foc_decode = SEL_PFC;
      default: foc_decode = SEL_NONE;
    endcase
  endfunction

endpackage

/* File: rtl/foc_timer.sv */
`timescale 1ns/1ps
module foc_timer
  import foc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic [TMR_W-1:0] load_val,
  output logic expired
);

  logic [TMR_W-1:0] count_r;

  // Down counter; a fresh load restarts the wait.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= '0;
    else if (load)
      count_r <= load_val;
    else if (count_r != '0)
      count_r <= count_r - TMR_ONE;
  end

  // One-cycle pulse when the wait runs out; a reload cancels it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      expired <= 1'b0;
    else
      expired <= !load && (count_r == TMR_ONE);
  end

endmodule // foc_timer

/* File: rtl/foc_ctrl.sv */
`timescale 1ns/1ps
// Functional notes
// (RL1) Program suspend request sets done within 11.5 us plus four clocks.
// (RL2) Erase suspend request sets done within 20.8 us plus four clocks.
// (RL3) Clearing a suspend bit with high voltage enabled resumes; done falls within 100 ns.
// (RL4) Rising high_voltage_enable starts program or erase; done clears within 5 ns.
// (RL5) Falling high_voltage_enable aborts the operation; done sets within 20.8 us plus four clocks.
// (RL6) After low power exit the flash is usable after 16 to 45 us plus seven clocks.
// (RL7) Rising integrity_check_enable starts a check; check done clears within 5 ns.
// (RL8) Resuming a suspended or breakpointed check clears check done within 5 ns.
// (RL9) Falling enable aborts an integrity check; check done sets within 80 ns plus fifteen clocks.
// (RL10) Suspending an integrity check sets check done within 80 ns plus fifteen clocks.
// (RL11) Falling enable aborts a margin read; check done sets within 10.36 to 20.42 us.
// (RL12) Suspending a margin read sets check done within 10.36 to 20.42 us plus four clocks.
// (RL13) Software programs wait states 2 or 3 and pipeline 1 at 100 or 133 MHz.
// (RL14) Done and check done stay at 1 while nothing is in progress.
module foc_ctrl
  import foc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic flash_done,
  output logic check_done,
  output logic flash_usable
);

  logic aw_have_r, w_have_r, wr_go, wr_ctrl, wr_chk;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  foc_ctrl_t ctrl_r, new_ctrl;
  foc_chk_t chk_r, new_chk;
  logic [5:0] pfc_r;
  foc_fst_t fst_r;
  foc_cst_t cst_r;
  logic [TMR_W-1:0] op_left_r, chk_left_r, f_val, c_val;
  logic f_load, f_exp, c_load, c_exp, r_load, r_exp, stop_susp_r;
  logic hve_rise, hve_fall, psus_rise, esus_rise, sus_fall;
  logic aie_rise, aie_fall, csus_rise, csus_fall, brk_fall;

  // Write address and data are latched independently, in either order.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_r <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_r <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
    begin
      aw_have_r <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_r <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_go)
    begin
      w_have_r <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  // A write commits once both halves are held and the last response is gone.
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_ctrl = wr_go && (foc_decode(awaddr_r) == SEL_CTRL) && wstrb_r[0];
  assign wr_chk = wr_go && (foc_decode(awaddr_r) == SEL_CHK) && wstrb_r[0];
  assign new_ctrl = foc_ctrl_t'(wdata_r[4:0]);
  assign new_chk = foc_chk_t'(wdata_r[3:0]);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (foc_decode(awaddr_r) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control edges are seen at the very edge that commits the write, so a start or resume drops done in one cycle.
  assign hve_rise = wr_ctrl && new_ctrl.high_voltage_enable && !ctrl_r.high_voltage_enable;
  assign hve_fall = wr_ctrl && !new_ctrl.high_voltage_enable && ctrl_r.high_voltage_enable;
  assign psus_rise = wr_ctrl && new_ctrl.program_suspend && !ctrl_r.program_suspend;
  assign esus_rise = wr_ctrl && new_ctrl.erase_suspend && !ctrl_r.erase_suspend;
  assign sus_fall = wr_ctrl && new_ctrl.high_voltage_enable &&
    ((ctrl_r.program_suspend && !new_ctrl.program_suspend) ||
     (ctrl_r.erase_suspend && !new_ctrl.erase_suspend));
  assign aie_rise = wr_chk && new_chk.integrity_check_enable && !chk_r.integrity_check_enable;
  assign aie_fall = wr_chk && !new_chk.integrity_check_enable && chk_r.integrity_check_enable;
  assign csus_rise = wr_chk && new_chk.integrity_check_suspend && !chk_r.integrity_check_suspend;
  assign csus_fall = wr_chk && !new_chk.integrity_check_suspend && chk_r.integrity_check_suspend;
  assign brk_fall = wr_chk && !new_chk.integrity_breakpoint_ctrl && chk_r.integrity_breakpoint_ctrl;

  // Software-visible control words; wait states and pipeline are only stored for the read path.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= '0;
      chk_r <= '0;
      pfc_r <= PFC_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= new_ctrl;
      if (wr_chk)
        chk_r <= new_chk;
      if (wr_go && (foc_decode(awaddr_r) == SEL_PFC) && wstrb_r[0])
        pfc_r <= wdata_r[5:0]; // RL13
    end
  end

  // Timer loads for the suspend and abort waits of both sequencers and for the recovery wait.
  always_comb
  begin
    f_load = 1'b0;
    f_val = '0;
    if ((fst_r == F_RUN || fst_r == F_SUSP_WAIT) && hve_fall)
    begin
      f_load = 1'b1;
      f_val = TMR_W'(ESUS_CYC); // RL5
    end
    else if (fst_r == F_RUN && psus_rise && !ctrl_r.erase_sel)
    begin
      f_load = 1'b1;
      f_val = TMR_W'(PSUS_CYC); // RL1
    end
    else if (fst_r == F_RUN && esus_rise && ctrl_r.erase_sel)
    begin
      f_load = 1'b1;
      f_val = TMR_W'(ESUS_CYC); // RL2
    end
    c_load = (cst_r == C_RUN) && (aie_fall || csus_rise);
    // The sequencer adds one cycle after expiry, so the tight integrity limit loads one less.
    c_val = chk_r.margin_sel ? TMR_W'(MR_STOP_CYC) : TMR_W'(AI_STOP_CYC - 1); // RL9 RL10 RL11 RL12
    r_load = wr_ctrl && ctrl_r.low_power && !new_ctrl.low_power;
  end

  foc_timer u_ftmr (.aclk(aclk), .aresetn(aresetn), .load(f_load), .load_val(f_val), .expired(f_exp));
  foc_timer u_ctmr (.aclk(aclk), .aresetn(aresetn), .load(c_load), .load_val(c_val), .expired(c_exp));
  foc_timer u_rtmr (.aclk(aclk), .aresetn(aresetn), .load(r_load), .load_val(TMR_W'(RCV_CYC)), .expired(r_exp));

  // Low power entry makes the array unusable until the recovery wait ends.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flash_usable <= 1'b1;
    else if (wr_ctrl && new_ctrl.low_power && !ctrl_r.low_power)
      flash_usable <= 1'b0;
    else if (r_exp && !ctrl_r.low_power)
      flash_usable <= 1'b1; // RL6
  end

  // Program and erase sequencer; a start while the array recovers is ignored.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fst_r <= F_IDLE;
      op_left_r <= '0;
      flash_done <= 1'b1;
    end
    else
    begin
      case (fst_r)
        F_IDLE:
          if (hve_rise && flash_usable)
          begin
            fst_r <= F_RUN;
            op_left_r <= new_ctrl.erase_sel ? ERS_RUN_CYC : PGM_RUN_CYC;
            flash_done <= 1'b0; // RL4
          end
        F_RUN:
          if (hve_fall)
            fst_r <= F_ABORT; // RL5
          else if (f_load)
            fst_r <= F_SUSP_WAIT;
          else if (op_left_r == TMR_ONE)
          begin
            fst_r <= F_END;
            flash_done <= 1'b1;
          end
          else
            op_left_r <= op_left_r - TMR_ONE;
        F_SUSP_WAIT:
          if (hve_fall)
            fst_r <= F_ABORT;
          else if (f_exp)
          begin
            fst_r <= F_SUSP;
            flash_done <= 1'b1; // RL1 RL2
          end
        F_SUSP:
          if (hve_fall)
            fst_r <= F_IDLE; // RL14
          else if (sus_fall)
          begin
            fst_r <= F_RUN;
            flash_done <= 1'b0; // RL3
          end
        F_ABORT:
          if (f_exp)
          begin
            fst_r <= F_IDLE;
            flash_done <= 1'b1; // RL5
          end
        F_END:
          if (hve_fall)
            fst_r <= F_IDLE;
        default:
          fst_r <= F_IDLE;
      endcase
    end
  end

  // Integrity check and margin read sequencer.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cst_r <= C_IDLE;
      chk_left_r <= '0;
      stop_susp_r <= 1'b0;
      check_done <= 1'b1;
    end
    else
    begin
      case (cst_r)
        C_IDLE:
          if (aie_rise)
          begin
            cst_r <= C_RUN;
            chk_left_r <= new_chk.margin_sel ? MR_RUN_CYC : AI_RUN_CYC;
            check_done <= 1'b0; // RL7
          end
        C_RUN:
          if (c_load)
          begin
            cst_r <= C_STOP;
            stop_susp_r <= !aie_fall;
          end
          else if (chk_r.integrity_breakpoint_ctrl)
          begin
            cst_r <= C_BRK;
            check_done <= 1'b1;
          end
          else if (chk_left_r == TMR_ONE)
          begin
            cst_r <= C_END;
            check_done <= 1'b1;
          end
          else
            chk_left_r <= chk_left_r - TMR_ONE;
        C_STOP:
          if (c_exp)
          begin
            cst_r <= stop_susp_r ? C_SUSP : C_IDLE;
            check_done <= 1'b1; // RL9 RL10 RL11 RL12
          end
        C_SUSP:
          if (aie_fall)
            cst_r <= C_IDLE;
          else if (csus_fall)
          begin
            cst_r <= C_RUN;
            check_done <= 1'b0; // RL8
          end
        C_BRK:
          if (aie_fall)
            cst_r <= C_IDLE;
          else if (brk_fall)
          begin
            cst_r <= C_RUN;
            check_done <= 1'b0; // RL8
          end
        C_END:
          if (aie_fall)
            cst_r <= C_IDLE; // RL14
        default:
          cst_r <= C_IDLE;
      endcase
    end
  end

  // Read channel; one read at a time, unmapped words answer with an error and zero data.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (foc_decode(s_axi_araddr))
        SEL_CTRL: s_axi_rdata <= {27'h0000000, ctrl_r};
        SEL_STAT: s_axi_rdata <= {28'h0000000, fst_r == F_SUSP, fst_r != F_IDLE, flash_usable, flash_done};
        SEL_CHK: s_axi_rdata <= {27'h0000000, check_done, chk_r};
        SEL_PFC: s_axi_rdata <= {26'h0000000, pfc_r};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Cycle counters that only the checks below read.
  logic [12:0] hf_cnt_r, hc_cnt_r, hr_cnt_r;
  foc_fst_t hf_st_r;
  foc_cst_t hc_st_r;
  always_ff @(posedge aclk)
  begin
    hf_st_r <= fst_r;
    hc_st_r <= cst_r;
    hf_cnt_r <= (fst_r != hf_st_r) ? 13'h0001 : hf_cnt_r + 13'h0001;
    hc_cnt_r <= (cst_r != hc_st_r) ? 13'h0001 : hc_cnt_r + 13'h0001;
    hr_cnt_r <= r_load ? 13'h0000 : hr_cnt_r + 13'h0001;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_start_clear: assert property (fst_r == F_IDLE && hve_rise && flash_usable |-> ##START_MAX_CYC !flash_done) // RL4
    else $error("done did not clear after start");
  a_psus_time: assert property (fst_r == F_SUSP_WAIT && f_exp && !ctrl_r.erase_sel && !hve_fall
    |-> hf_cnt_r <= PSUS_MAX_CYC ##1 flash_done) // RL1
    else $error("program suspend answered late");
  a_esus_time: assert property (fst_r == F_SUSP_WAIT && f_exp && ctrl_r.erase_sel && !hve_fall
    |-> hf_cnt_r <= ESUS_MAX_CYC ##1 flash_done) // RL2
    else $error("erase suspend answered late");
  a_resume_low: assert property (fst_r == F_SUSP && sus_fall && !hve_fall |=> !flash_done && fst_r == F_RUN) // RL3
    else $error("resume did not drop done");
  a_abort_done: assert property (fst_r == F_ABORT && f_exp |-> hf_cnt_r <= ESUS_MAX_CYC ##1 flash_done) // RL5
    else $error("abort answered late");
  a_recover_time: assert property ($rose(flash_usable) |-> hr_cnt_r >= RCV_CYC && hr_cnt_r <= RCV_MAX_CYC) // RL6
    else $error("recovery time out of range");
  a_chk_start: assert property (cst_r == C_IDLE && aie_rise |=> !check_done) // RL7
    else $error("check done did not clear");
  a_chk_resume: assert property ((cst_r == C_SUSP && csus_fall || cst_r == C_BRK && brk_fall) && !aie_fall
    |=> !check_done) // RL8
    else $error("check resume did not clear done");
  a_ai_stop: assert property (cst_r == C_RUN && c_load && !chk_r.margin_sel |-> ##[1:36] check_done) // RL9 RL10
    else $error("integrity stop answered late");
  a_mr_stop: assert property (cst_r == C_STOP && c_exp && chk_r.margin_sel
    |-> hc_cnt_r >= MR_STOP_CYC && hc_cnt_r <= MR_STOP_MAX_CYC) // RL11 RL12
    else $error("margin stop time out of range");
  a_idle_done: assert property (fst_r == F_IDLE && cst_r == C_IDLE |-> flash_done && check_done) // RL14
    else $error("done low while idle");

  c_prog_suspend: cover property (fst_r == F_SUSP && sus_fall);
  c_erase_abort: cover property (fst_r == F_ABORT && f_exp);
  c_margin_stop: cover property (cst_r == C_STOP && c_exp && chk_r.margin_sel);
  c_recovery: cover property ($rose(flash_usable));

endmodule // foc_ctrl

/* File: verification/flash_op_control_timing_tb_top.sv */
`timescale 1ns/1ps
module flash_op_control_timing_tb_top;
  import foc_pkg::*;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic flash_done, check_done, flash_usable;
  int fails, comparisons, n;

  foc_ctrl u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .flash_done, .check_done, .flash_usable
  );

  // Free running 250 MHz clock.
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic inrange(input string nm, input int cnt, input int lo, input int hi);
    chk(nm, {31'h0, (cnt >= lo && cnt <= hi)}, 32'h1);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Both channels are offered together and each is released at the edge that takes it.
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic flag(input int sel);
    case (sel)
      0: flag = flash_done;
      1: flag = check_done;
      default: flag = flash_usable;
    endcase
  endfunction

  // Counts edges after a write returns until the chosen flag is high; the bound stops a hang.
  task automatic wait_for(input int sel, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge aclk);
      cnt++;
    end
    while (flag(sel) !== 1'b1 && cnt < 30000);
  endtask

  // Cuts the run short if a wait never ends; all tests need well under this span.
  initial
  begin
    repeat (60000) @(posedge aclk);
    fails++;
    end_of_test;
  end

  // Main sequence: reset, then register, program, erase, power and check tests.
  initial
  begin
    fails = 0;
    comparisons = 0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_STAT, rdat, resp);
    chk("stat reset", rdat, 32'h3);
    rd(OFF_CHK, rdat, resp);
    chk("chk reset", rdat, 32'h10);
    rd(OFF_PFC, rdat, resp);
    chk("pfc reset", rdat, {26'h0, PFC_RST});
    wr(OFF_PFC, 32'h12);
    axi_wr(OFF_PFC, 32'h3F, 4'h0, resp);
    rd(OFF_PFC, rdat, resp);
    chk("pfc wait states and pipeline", rdat, 32'h12);
    axi_wr(12'h010, 32'h1, 4'hF, resp);
    chk("unmapped write resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    rd(12'h010, rdat, resp);
    chk("unmapped read resp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    chk("unmapped read data", rdat, 32'h0);
    $display("test registers done");
    // Program start then immediate abort.
    wr(OFF_CTRL, 32'h1);
    chk("done after start", {31'h0, flash_done}, 32'h0);
    rd(OFF_STAT, rdat, resp);
    chk("stat busy", rdat, 32'h6);
    wr(OFF_CTRL, 32'h0);
    wait_for(0, n);
    inrange("abort time", n, 1, ESUS_MAX_CYC);
    // Program suspend, resume, completion.
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h3);
    wait_for(0, n);
    inrange("program suspend time", n, 1, PSUS_MAX_CYC);
    wr(OFF_CTRL, 32'h1);
    chk("done after resume", {31'h0, flash_done}, 32'h0);
    wait_for(0, n);
    repeat (5) @(posedge aclk);
    chk("done held after end", {31'h0, flash_done}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    $display("test program done");
    // Erase suspend, then clear enable while suspended.
    wr(OFF_CTRL, 32'h9);
    chk("done after erase start", {31'h0, flash_done}, 32'h0);
    wr(OFF_CTRL, 32'hD);
    wait_for(0, n);
    inrange("erase suspend time", n, 1, ESUS_MAX_CYC);
    wr(OFF_CTRL, 32'h8);
    rd(OFF_STAT, rdat, resp);
    chk("stat idle after suspended abort", rdat, 32'h3);
    $display("test erase done");
    // Low power entry, a start that must be ignored, then recovery.
    wr(OFF_CTRL, 32'h10);
    chk("usable in low power", {31'h0, flash_usable}, 32'h0);
    wr(OFF_CTRL, 32'h11);
    chk("no start while unusable", {31'h0, flash_done}, 32'h1);
    wr(OFF_CTRL, 32'h0);
    wait_for(2, n);
    inrange("recovery time", n, RCV_CYC, RCV_MAX_CYC);
    $display("test low power done");
    // Integrity check abort, suspend, resume, breakpoint and completion.
    wr(OFF_CHK, 32'h1);
    chk("check done after start", {31'h0, check_done}, 32'h0);
    wr(OFF_CHK, 32'h0);
    wait_for(1, n);
    inrange("integrity abort time", n, 1, AI_STOP_CYC);
    wr(OFF_CHK, 32'h1);
    wr(OFF_CHK, 32'h3);
    wait_for(1, n);
    inrange("integrity suspend time", n, 1, AI_STOP_CYC);
    wr(OFF_CHK, 32'h1);
    chk("check done after resume", {31'h0, check_done}, 32'h0);
    wr(OFF_CHK, 32'h5);
    wait_for(1, n);
    inrange("breakpoint halt", n, 1, 2);
    wr(OFF_CHK, 32'h1);
    chk("check done after breakpoint clear", {31'h0, check_done}, 32'h0);
    wait_for(1, n);
    rd(OFF_CHK, rdat, resp);
    chk("chk after completion", rdat, 32'h11);
    wr(OFF_CHK, 32'h0);
    $display("test integrity done");
    // Margin read abort and suspend.
    wr(OFF_CHK, 32'h9);
    chk("check done after margin start", {31'h0, check_done}, 32'h0);
    wr(OFF_CHK, 32'h8);
    wait_for(1, n);
    inrange("margin abort time", n, MR_STOP_CYC, MR_STOP_MAX_CYC);
    wr(OFF_CHK, 32'h9);
    wr(OFF_CHK, 32'hB);
    wait_for(1, n);
    inrange("margin suspend time", n, MR_STOP_CYC, MR_STOP_MAX_CYC);
    wr(OFF_CHK, 32'h0);
    repeat (5) @(posedge aclk);
    chk("check done held idle", {31'h0, check_done}, 32'h1);
    $display("test margin done");
    end_of_test;
  end
endmodule // flash_op_control_timing_tb_top
